// ### core/usbif_defines.vh
`ifndef USBIF_DEFINES_VH
`define USBIF_DEFINES_VH

// Register locations in the microcontroller data memory.
`define USBIF_ADDR_DIR 8'h41
`define USBIF_ADDR_DEVADR 8'h42
`define USBIF_ADDR_HALT 8'h43
`define USBIF_ADDR_ACCESS 8'h44
`define USBIF_ADDR_STATUS 8'h45
`define USBIF_ADDR_BUFCMD 8'h46
`define USBIF_ADDR_BUF0 8'h48
`define USBIF_ADDR_BUF1 8'h49

// Reset values.
`define USBIF_RST_DIR 2'h3
`define USBIF_RST_DEVADR 8'h00
`define USBIF_RST_HALT 2'h0
`define USBIF_RST_ACCESS 2'h0
`define USBIF_RST_DEVICE_ID 7'h00

// Field positions of the engine status and control register.
`define USBIF_ST_ADRSET 0
`define USBIF_ST_EP0ERR 1
`define USBIF_ST_NAKMASK 7

// Field positions of the buffer command and status register.
`define USBIF_BC_REQ 0
`define USBIF_BC_TX 1
`define USBIF_BC_CLR 2
`define USBIF_BC_SEL0 3
`define USBIF_BC_SEL1 4
`define USBIF_BC_SETUP 5
`define USBIF_BC_READY 6
`define USBIF_BC_LEN0 7

// Remote wake-up flag position in the address register.
`define USBIF_WAKEUP_BIT 0

// Endpoint buffer geometry: eight bytes per endpoint.
`define USBIF_BUF_DEPTH 8
`define USBIF_BUF_AW 3
`define USBIF_BUF_CW 4

`endif

// ### core/usbif_buf.v
`timescale 1ns/1ns
`include "usbif_defines.vh"

module usbif_buf
(
  // Clock and reset.
  input wire clk,
  input wire rst,
  // Control.
  input wire clr,
  input wire push,
  input wire pop,
  // Data.
  input wire [7:0] din,
  output wire [7:0] dout,
  // State.
  output wire empty,
  output wire full
);

  reg [7:0] mem_q [0:`USBIF_BUF_DEPTH-1];
  reg [`USBIF_BUF_AW-1:0] wp_q;
  reg [`USBIF_BUF_AW-1:0] rp_q;
  reg [`USBIF_BUF_CW-1:0] cnt_q;
  integer i;

  assign empty = (cnt_q == 4'h0);
  assign full = (cnt_q == 4'h8);
  assign dout = mem_q[rp_q];

  ////////////////////////////////////////////////////////////////////////
  // Pointers and count; clear wins over any transfer in the same cycle.
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wp_q <= 3'h0;
      rp_q <= 3'h0;
      cnt_q <= 4'h0;
    end
    else if (clr)
    begin
      wp_q <= 3'h0;
      rp_q <= 3'h0;
      cnt_q <= 4'h0;
    end
    else
    begin
      if (push && !full)
        wp_q <= wp_q + 3'h1;
      if (pop && !empty)
        rp_q <= rp_q + 3'h1;
      if ((push && !full) && !(pop && !empty))
        cnt_q <= cnt_q + 4'h1;
      else if (!(push && !full) && (pop && !empty))
        cnt_q <= cnt_q - 4'h1;
    end
  end

  // Storage in flip-flops, cleared at reset so reads are never unknown.
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      for (i = 0; i < `USBIF_BUF_DEPTH; i = i + 1)
        mem_q[i] <= 8'h00;
    end
    else if (push && !full && !clr)
      mem_q[wp_q] <= din;
  end

endmodule // usbif_buf

// ### core/usbif_regs.v
// Summary of operation
// - An 8-bit address register holds the device address above a wake-up flag in bit zero and resets to zero.
// - Bit zero of the address register reads one when remote wake-up exists and zero when it does not.
// - Each endpoint has a direction bit where one means IN and zero means OUT.
// - Endpoint one sits in bit one, endpoint zero in bit zero, upper bits reserved, reset value both IN.
// - The read-only access register sets an endpoint bit only after the host touched that endpoint and resets to zero.
// - When a host access raises the USB interrupt the access register already names the endpoint that caused it.
// - With the deferred bit set the engine loads the address only after the host completes an IN read.
// - After applying a deferred address the engine clears the deferred bit itself.
// - With the deferred bit clear a write to the address register applies the new address at once.
// - The engine sets the endpoint-zero error flag on buffer errors and firmware clears it.
// - Status bit seven masks the NAK interrupt when one and resets to zero.
// - Status bits two to six are reserved with no function.
// - Registers sit at consecutive data-memory locations with the two buffer ports after them.
// - Two eight-byte bidirectional buffers serve the control and the interrupt endpoint.
`timescale 1ns/1ns
`include "usbif_defines.vh"

module usbif_regs
(
  // Clock and reset.
  input wire clk,
  input wire rst,
  // Microcontroller data-memory port.
  input wire [7:0] mcu_addr,
  input wire mcu_wr,
  input wire mcu_rd,
  input wire [7:0] mcu_wdata,
  output reg [7:0] mcu_rdata_q,
  // Events from the serial engine.
  input wire [1:0] sie_host_access,
  input wire sie_in_done,
  input wire sie_ep0_err,
  input wire sie_setup_rx,
  input wire sie_zero_len,
  input wire sie_nak,
  // Serial engine buffer port.
  input wire sie_ep,
  input wire sie_push,
  input wire sie_pop,
  input wire [7:0] sie_wdata,
  output reg [7:0] sie_rdata_q,
  // Configuration towards the serial engine.
  output reg [6:0] dev_addr_q,
  output reg wakeup_en_q,
  output reg [1:0] ep_dir_q,
  output reg [1:0] ep_halt_q,
  output reg usb_int_q
);

  reg [7:0] adr_reg_q;
  reg [1:0] access_q;
  reg [1:0] access_d;
  reg adr_set_q;
  reg ep0_err_q;
  reg nak_mask_q;
  reg req_q;
  reg tx_q;
  reg clr_q;
  reg sel0_q;
  reg sel1_q;
  reg setup_q;
  reg len0_q;
  reg ready_q;
  reg [7:0] rd_mux;

  wire wr_dir;
  wire wr_adr;
  wire wr_halt;
  wire wr_stat;
  wire wr_bc;
  wire wr_b0;
  wire wr_b1;
  wire rd_acc;
  wire rd_b0;
  wire rd_b1;
  wire [7:0] dout0;
  wire [7:0] dout1;
  wire empty0;
  wire empty1;
  wire full0;
  wire full1;
  wire sel_b1;
  wire act0;
  wire act1;
  wire mpush0;
  wire mpush1;
  wire mpop0;
  wire mpop1;
  wire spush0;
  wire spush1;
  wire spop0;
  wire spop1;
  wire ready_d;

  //////////////////////////////////////////////////////////////////////////
  // Address decode; the register bank is a run of consecutive locations.
  assign wr_dir = mcu_wr && (mcu_addr == `USBIF_ADDR_DIR);
  assign wr_adr = mcu_wr && (mcu_addr == `USBIF_ADDR_DEVADR);
  assign wr_halt = mcu_wr && (mcu_addr == `USBIF_ADDR_HALT);
  assign wr_stat = mcu_wr && (mcu_addr == `USBIF_ADDR_STATUS);
  assign wr_bc = mcu_wr && (mcu_addr == `USBIF_ADDR_BUFCMD);
  assign wr_b0 = mcu_wr && (mcu_addr == `USBIF_ADDR_BUF0);
  assign wr_b1 = mcu_wr && (mcu_addr == `USBIF_ADDR_BUF1);
  assign rd_acc = mcu_rd && (mcu_addr == `USBIF_ADDR_ACCESS);
  assign rd_b0 = mcu_rd && (mcu_addr == `USBIF_ADDR_BUF0);
  assign rd_b1 = mcu_rd && (mcu_addr == `USBIF_ADDR_BUF1);

  //////////////////////////////////////////////////////////////////////////
  // Buffer arbitration. Firmware only reaches the buffer it selected while
  // its request is up; the engine uses a buffer otherwise and is refused a
  // transfer in a cycle where firmware moves a byte through the same one.
  assign sel_b1 = sel0_q;
  assign act0 = req_q && !sel_b1;
  assign act1 = req_q && sel_b1;
  assign mpush0 = wr_b0 && act0 && tx_q && !full0;
  assign mpush1 = wr_b1 && act1 && tx_q && !full1;
  assign mpop0 = rd_b0 && act0 && !tx_q && !empty0;
  assign mpop1 = rd_b1 && act1 && !tx_q && !empty1;
  assign spush0 = sie_push && !sie_ep && !mpush0 && !mpop0;
  assign spush1 = sie_push && sie_ep && !mpush1 && !mpop1;
  assign spop0 = sie_pop && !sie_ep && !mpush0 && !mpop0;
  assign spop1 = sie_pop && sie_ep && !mpush1 && !mpop1;

  // Ready: room to write when sending, data to read when receiving.
  assign ready_d = act0 ? (tx_q ? !full0 : !empty0) :
                   act1 ? (tx_q ? !full1 : !empty1) : 1'b0;

  //////////////////////////////////////////////////////////////////////////
  // Control endpoint buffer.
  usbif_buf u_buf0
  (
    .clk(clk),
    .rst(rst),
    .clr(clr_q && act0),
    .push(mpush0 || spush0),
    .pop(mpop0 || spop0),
    .din(mpush0 ? mcu_wdata : sie_wdata),
    .dout(dout0),
    .empty(empty0),
    .full(full0)
  );

  // Interrupt endpoint buffer.
  usbif_buf u_buf1
  (
    .clk(clk),
    .rst(rst),
    .clr(clr_q && act1),
    .push(mpush1 || spush1),
    .pop(mpop1 || spop1),
    .din(mpush1 ? mcu_wdata : sie_wdata),
    .dout(dout1),
    .empty(empty1),
    .full(full1)
  );

  //////////////////////////////////////////////////////////////////////////
  // Direction and halt bitmaps; only the two endpoint bits are stored.
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ep_dir_q <= `USBIF_RST_DIR;
      ep_halt_q <= `USBIF_RST_HALT;
    end
    else
    begin
      if (wr_dir)
        ep_dir_q <= mcu_wdata[1:0];
      if (wr_halt)
        ep_halt_q <= mcu_wdata[1:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Address register, applied address and the deferred-update bit.
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      adr_reg_q <= `USBIF_RST_DEVADR;
      dev_addr_q <= `USBIF_RST_DEVICE_ID;
      wakeup_en_q <= 1'b0;
      adr_set_q <= 1'b0;
    end
    else
    begin
      if (wr_adr)
      begin
        adr_reg_q <= mcu_wdata;
        wakeup_en_q <= mcu_wdata[`USBIF_WAKEUP_BIT];
      end
      if (wr_adr && !adr_set_q)
        dev_addr_q <= mcu_wdata[7:1];
      else if (adr_set_q && sie_in_done)
        dev_addr_q <= adr_reg_q[7:1];
      // The engine's own clear beats a firmware write in the same cycle,
      // so a stale deferred update can never fire twice.
      if (adr_set_q && sie_in_done)
        adr_set_q <= 1'b0;
      else if (wr_stat)
        adr_set_q <= mcu_wdata[`USBIF_ST_ADRSET];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Error flag and NAK mask. The hardware set wins over a firmware clear.
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ep0_err_q <= 1'b0;
      nak_mask_q <= 1'b0;
    end
    else
    begin
      if (sie_ep0_err)
        ep0_err_q <= 1'b1;
      else if (wr_stat)
        ep0_err_q <= mcu_wdata[`USBIF_ST_EP0ERR];
      if (wr_stat)
        nak_mask_q <= mcu_wdata[`USBIF_ST_NAKMASK];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Access flags clear on a read, but a host access in that same cycle is
  // kept so that no interrupt cause is ever lost.
  always @*
  begin
    access_d = access_q;
    if (rd_acc)
      access_d = 2'h0;
    access_d = access_d | sie_host_access;
  end

  // The interrupt pulses in the same cycle that the flag becomes visible.
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      access_q <= `USBIF_RST_ACCESS;
      usb_int_q <= 1'b0;
    end
    else
    begin
      access_q <= access_d;
      usb_int_q <= (|sie_host_access) || (sie_nak && !nak_mask_q);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Buffer command and status register.
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      req_q <= 1'b0;
      tx_q <= 1'b0;
      clr_q <= 1'b0;
      sel0_q <= 1'b0;
      sel1_q <= 1'b0;
      setup_q <= 1'b0;
      len0_q <= 1'b0;
      ready_q <= 1'b0;
    end
    else
    begin
      ready_q <= ready_d;
      if (wr_bc)
      begin
        req_q <= mcu_wdata[`USBIF_BC_REQ];
        tx_q <= mcu_wdata[`USBIF_BC_TX];
        clr_q <= mcu_wdata[`USBIF_BC_CLR];
        sel0_q <= mcu_wdata[`USBIF_BC_SEL0];
        sel1_q <= mcu_wdata[`USBIF_BC_SEL1];
      end
      // A new setup packet must not be missed while firmware is busy.
      if (sie_setup_rx)
        setup_q <= 1'b1;
      else if (wr_bc)
        setup_q <= mcu_wdata[`USBIF_BC_SETUP];
      // Zero-length flag: reading the control buffer or a new setup clears.
      if (sie_zero_len)
        len0_q <= 1'b1;
      else if (rd_b0 || sie_setup_rx)
        len0_q <= 1'b0;
      else if (wr_bc)
        len0_q <= mcu_wdata[`USBIF_BC_LEN0];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read multiplexer; unmapped and reserved locations read as zero.
  always @*
  begin
    rd_mux = 8'h00;
    case (mcu_addr)
      `USBIF_ADDR_DIR: rd_mux = {6'h00, ep_dir_q};
      `USBIF_ADDR_DEVADR: rd_mux = adr_reg_q;
      `USBIF_ADDR_HALT: rd_mux = {6'h00, ep_halt_q};
      `USBIF_ADDR_ACCESS: rd_mux = {6'h00, access_q};
      `USBIF_ADDR_STATUS: rd_mux = {nak_mask_q, 5'h00, ep0_err_q,
                                    adr_set_q};
      `USBIF_ADDR_BUFCMD: rd_mux = {len0_q, ready_q, setup_q, sel1_q,
                                    sel0_q, clr_q, tx_q, req_q};
      `USBIF_ADDR_BUF0: rd_mux = mpop0 ? dout0 : 8'h00;
      `USBIF_ADDR_BUF1: rd_mux = mpop1 ? dout1 : 8'h00;
      default: rd_mux = 8'h00;
    endcase
  end

  // Read data is captured on the read strobe and held until the next one.
  always @(posedge clk or posedge rst)
  begin
    if (rst)
      mcu_rdata_q <= 8'h00;
    else if (mcu_rd)
      mcu_rdata_q <= rd_mux;
  end

  //////////////////////////////////////////////////////////////////////////
  // Engine side read data, captured from the head of the buffer it pops.
  always @(posedge clk or posedge rst)
  begin
    if (rst)
      sie_rdata_q <= 8'h00;
    else if (spop0)
      sie_rdata_q <= dout0;
    else if (spop1)
      sie_rdata_q <= dout1;
  end

endmodule // usbif_regs

// ### verif/usbif_chk_sva.sv
`timescale 1ns/1ns
////////////////////////////////////////
module usbif_chk
(
  // Clock and reset.
  input wire clk,
  input wire rst,
  // Register port.
  input wire [7:0] mcu_addr,
  input wire mcu_wr,
  input wire mcu_rd,
  input wire [7:0] mcu_wdata,
  input wire [7:0] mcu_rdata_q,
  // Engine events.
  input wire [1:0] sie_host_access,
  input wire sie_in_done,
  input wire sie_nak,
  // Outputs under watch.
  input wire [6:0] dev_addr_q,
  input wire wakeup_en_q,
  input wire [1:0] ep_dir_q,
  input wire [1:0] ep_halt_q,
  input wire usb_int_q
);
  reg set_q;
  reg mask_q;
  reg [7:0] wd_q;
  reg [6:0] adr_q;
  wire w42 = mcu_wr && mcu_addr == 8'h42;
  wire w45 = mcu_wr && mcu_addr == 8'h45;
  // Shadows; the engine clear wins over a same-cycle write.
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      set_q <= 1'b0;
      mask_q <= 1'b0;
      wd_q <= 8'h00;
      adr_q <= 7'h00;
    end
    else
    begin
      wd_q <= mcu_wdata;
      if (w42)
        adr_q <= mcu_wdata[7:1];
      if (w45)
        mask_q <= mcu_wdata[7];
      if (set_q && sie_in_done)
        set_q <= 1'b0;
      else if (w45)
        set_q <= mcu_wdata[0];
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_now; w42 && !set_q |=> dev_addr_q == adr_q; endproperty
  a_now: assert property (p_now) else $error("address late");
  property p_wake; w42 |=> wakeup_en_q == wd_q[0]; endproperty
  a_wake: assert property (p_wake) else $error("wakeup bad");
  property p_defer;
    set_q && sie_in_done |=> dev_addr_q == $past(adr_q);
  endproperty
  a_defer: assert property (p_defer) else $error("defer bad");
  property p_hold; set_q && !sie_in_done |=> $stable(dev_addr_q); endproperty
  a_hold: assert property (p_hold) else $error("addr moved");
  property p_dir; mcu_wr && mcu_addr == 8'h41 |=> ep_dir_q == wd_q[1:0];
  endproperty
  a_dir: assert property (p_dir) else $error("dir bad");
  property p_halt; mcu_wr && mcu_addr == 8'h43 |=> ep_halt_q == wd_q[1:0];
  endproperty
  a_halt: assert property (p_halt) else $error("halt bad");
  property p_rdir;
    mcu_rd && mcu_addr == 8'h41 |=> mcu_rdata_q == {6'h00, $past(ep_dir_q)};
  endproperty
  a_rdir: assert property (p_rdir) else $error("dir read bad");
  property p_int; |sie_host_access |=> usb_int_q; endproperty
  a_int: assert property (p_int) else $error("no int");
  property p_nak; sie_nak && !mask_q |=> usb_int_q; endproperty
  a_nak: assert property (p_nak) else $error("nak lost");
  property p_mask;
    sie_nak && mask_q && sie_host_access == 2'h0 |=> !usb_int_q;
  endproperty
  a_mask: assert property (p_mask) else $error("nak unmasked");
  c_defer: cover property (set_q && sie_in_done);
  c_mask: cover property (sie_nak && mask_q);
  c_int: cover property (usb_int_q);
endmodule // usbif_chk

// ### verif/usbif_sie_model.sv
`timescale 1ns/1ns
////////////////////////////////////////
module usbif_sie_model
(
  // Clock.
  input wire clk,
  // Event pulses.
  output wire [1:0] sie_host_access,
  output wire sie_in_done,
  output wire sie_ep0_err,
  output wire sie_setup_rx,
  output wire sie_zero_len,
  output wire sie_nak,
  // Buffer port.
  output wire sie_ep,
  output wire sie_push,
  output wire sie_pop,
  output reg [7:0] sie_wdata
);
  reg [9:0] ev_q = 10'h000;
  // Packed as select, pop, push, nak, len0, setup, err, done, access.
  assign {sie_ep, sie_pop, sie_push, sie_nak, sie_zero_len, sie_setup_rx,
    sie_ep0_err, sie_in_done, sie_host_access} = ev_q;
  initial
    sie_wdata = 8'h00;
  // One-cycle event; access pulses only name touched endpoints.
  task ev(input [9:0] m, input [7:0] d);
  begin
    @(negedge clk);
    ev_q = m;
    sie_wdata = d;
    @(negedge clk);
    ev_q = 10'h000;
    // Inverted so a released bus never shows the stale byte.
    sie_wdata = ~d;
  end
  endtask
endmodule // usbif_sie_model

// ### verif/test_usb_sie_mcu_register_interface.sv
`timescale 1ns/1ns
////////////////////////////////////////
module test_usb_sie_mcu_register_interface;
  reg clk;
  reg rst;
  reg [7:0] mcu_addr;
  reg mcu_wr;
  reg mcu_rd;
  reg [7:0] mcu_wdata;
  wire [7:0] mcu_rdata_q, sie_rdata_q, sie_wdata;
  wire [6:0] dev_addr_q;
  wire [1:0] ep_dir_q, ep_halt_q, sie_host_access;
  wire wakeup_en_q, usb_int_q, sie_in_done, sie_ep0_err, sie_setup_rx;
  wire sie_zero_len, sie_nak, sie_ep, sie_push, sie_pop;
  integer err_count = 0;
  integer total_checks = 0;
  integer i;
  // Address, write data, read-back value.
  reg [23:0] rows [0:8] = '{24'h41ff03, 24'h410000, 24'h420b0b, 24'h43fe02,
    24'h44ff00, 24'h45fe82, 24'h450000, 24'h4fff00, 24'h40ff00};
  usbif_regs usbif_regs_inst (.clk, .rst, .mcu_addr, .mcu_wr, .mcu_rd,
    .mcu_wdata, .mcu_rdata_q, .sie_host_access, .sie_in_done, .sie_ep0_err,
    .sie_setup_rx, .sie_zero_len, .sie_nak, .sie_ep, .sie_push, .sie_pop,
    .sie_wdata, .sie_rdata_q, .dev_addr_q, .wakeup_en_q, .ep_dir_q,
    .ep_halt_q, .usb_int_q);
  usbif_sie_model usbif_sie_model_inst (.clk, .sie_host_access, .sie_in_done,
    .sie_ep0_err, .sie_setup_rx, .sie_zero_len, .sie_nak, .sie_ep,
    .sie_push, .sie_pop, .sie_wdata);
  ////////////////////////////////////////
  task chk(input [7:0] s, input [7:0] e);
  begin
    total_checks = total_checks + 1;
    if (s !== e)
    begin
      err_count = err_count + 1;
      $display("[FAIL] %0t got %h want %h", $time, s, e);
    end
  end
  endtask
  task wr(input [7:0] a, input [7:0] d);
  begin
    @(negedge clk);
    mcu_addr = a;
    mcu_wdata = d;
    mcu_wr = 1'b1;
    @(negedge clk);
    mcu_wr = 1'b0;
  end
  endtask
  // Read data is registered, so it is checked one edge after the strobe.
  task rd(input [7:0] a, input [7:0] e);
  begin
    @(negedge clk);
    mcu_addr = a;
    mcu_rd = 1'b1;
    @(negedge clk);
    mcu_rd = 1'b0;
    chk(mcu_rdata_q, e);
  end
  endtask
  task end_sim;
  begin
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  end
  endtask
  ////////////////////////////////////////
  // Free-running system clock.
  initial
  begin
    clk = 1'b0;
    forever
      #5 clk = ~clk;
  end
  // Main sequence.
  initial
  begin
    rst = 1'b1;
    mcu_addr = 8'h00;
    mcu_wdata = 8'h00;
    mcu_wr = 1'b0;
    mcu_rd = 1'b0;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    for (i = 'h41; i < 'h47; i = i + 1)
      rd(i[7:0], i == 'h41 ? 8'h03 : 8'h00);
    for (i = 0; i < 9; i = i + 1)
    begin
      wr(rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16], rows[i][7:0]);
    end
    // A new address value, so a lost write cannot pass unseen.
    wr(8'h42, 8'h0c);
    chk({1'b0, dev_addr_q}, 8'h06);
    chk({7'h00, wakeup_en_q}, 8'h00);
    wr(8'h45, 8'h01);
    wr(8'h42, 8'h10);
    chk({1'b0, dev_addr_q}, 8'h06);
    usbif_sie_model_inst.ev(10'h004, 8'h00);
    chk({1'b0, dev_addr_q}, 8'h08);
    rd(8'h45, 8'h00);
    usbif_sie_model_inst.ev(10'h002, 8'h00);
    chk({7'h00, usb_int_q}, 8'h01);
    rd(8'h44, 8'h02);
    rd(8'h44, 8'h00);
    wr(8'h45, 8'h80);
    usbif_sie_model_inst.ev(10'h040, 8'h00);
    chk({7'h00, usb_int_q}, 8'h00);
    wr(8'h45, 8'h00);
    usbif_sie_model_inst.ev(10'h040, 8'h00);
    chk({7'h00, usb_int_q}, 8'h01);
    usbif_sie_model_inst.ev(10'h008, 8'h00);
    rd(8'h45, 8'h02);
    wr(8'h45, 8'h00);
    rd(8'h45, 8'h00);
    usbif_sie_model_inst.ev(10'h020, 8'h00);
    rd(8'h46, 8'h80);
    usbif_sie_model_inst.ev(10'h010, 8'h00);
    rd(8'h46, 8'h20);
    wr(8'h46, 8'h00);
    // Engine fills the control buffer, firmware drains it.
    usbif_sie_model_inst.ev(10'h080, 8'h55);
    wr(8'h46, 8'h01);
    rd(8'h46, 8'h41);
    rd(8'h48, 8'h55);
    // Firmware fills the interrupt buffer, the engine drains it.
    wr(8'h46, 8'h0b);
    wr(8'h49, 8'ha5);
    wr(8'h46, 8'h00);
    usbif_sie_model_inst.ev(10'h300, 8'h00);
    chk(sie_rdata_q, 8'ha5);
    // Clear empties the selected buffer even while it still holds data.
    usbif_sie_model_inst.ev(10'h080, 8'h33);
    wr(8'h46, 8'h05);
    wr(8'h46, 8'h01);
    rd(8'h46, 8'h01);
    rd(8'h48, 8'h00);
    wr(8'h46, 8'h00);
    @(negedge clk);
    rst = 1'b1;
    #1;
    chk({6'h00, ep_dir_q}, 8'h03);
    chk({1'b0, dev_addr_q}, 8'h00);
    chk({6'h00, ep_halt_q}, 8'h00);
    @(negedge clk);
    rst = 1'b0;
    rd(8'h41, 8'h03);
    end_sim;
  end
endmodule // test_usb_sie_mcu_register_interface

bind usbif_regs usbif_chk usbif_chk_inst (.clk, .rst, .mcu_addr, .mcu_wr,
  .mcu_rd, .mcu_wdata, .mcu_rdata_q, .sie_host_access, .sie_in_done, .sie_nak,
  .dev_addr_q, .wakeup_en_q, .ep_dir_q, .ep_halt_q, .usb_int_q);
